// >>> logic/ssg_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssg_top
  import ssg_pkg::*;
#(
  parameter int SLOW_CYCLES = ssg_pkg::SSG_SLOW_CYCLES
) (
  // clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 ARST_N,
  // register port
  input  wire ssg_pkg::ssg_req_type REQ,
  output var  logic [15:0]          RDATA,
  output var  logic                 RVALID,
  // general pins
  input  wire logic                 PIN0_I,
  input  wire logic                 PIN1_I,
  output var  logic                 PIN1_O,
  output var  logic                 PIN1_OE_N,
  output var  logic                 PIN0_IN_EN,
  output var  logic                 PIN1_IN_EN,
  // timing
  output var  logic [7:0]           FAST_CLOCK_TRIM,
  output var  logic                 SAMPLE_START
);
  import ssg_pkg::*;

  typedef struct packed {
    logic [15:0] divider;
    logic [15:0] trim;
    logic [15:0] pincfg;
    logic [15:0] pinout;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] slow_cnt;
    logic [17:0] tick_cnt;
    logic        pin0_prev;
    logic        pin1_prev;
    logic        start;
    logic        pin1_o;
    logic        pin1_oe_n;
  } ssg_state_type;

  localparam ssg_state_type SSG_STATE_RST = '{
    divider:   SSG_RST_DIVIDER,
    trim:      SSG_RST_TRIM,
    pincfg:    SSG_RST_PINCFG,
    pinout:    SSG_RST_PINOUT,
    rdata:     16'h0000,
    rvalid:    1'b0,
    slow_cnt:  16'h0000,
    tick_cnt:  18'h00000,
    pin0_prev: 1'b0,
    pin1_prev: 1'b0,
    start:     1'b0,
    pin1_o:    1'b0,
    pin1_oe_n: 1'b1
  };

  logic          rst_meta_q;
  logic          rst_sync_q;
  ssg_state_type s_q;
  ssg_state_type s_d;

  // named views of the live register fields
  logic          pin0_input_enable;
  logic          pin1_input_enable;
  ssg_sync_type  sample_sync_select;
  logic [15:0]   sample_rate_divider;

  assign pin0_input_enable   = s_q.pincfg[SSG_BIT_PIN0_IE];
  assign pin1_input_enable   = s_q.pincfg[SSG_BIT_PIN1_IE];
  assign sample_sync_select  = ssg_sync_type'(s_q.pincfg[SSG_BIT_SYNC_LO +: 2]);
  assign sample_rate_divider = s_q.divider;

  // reset release through two flops
  // assertion acts at once; release waits two edges so no flop sees a runt
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  function automatic logic [15:0] read_reg(input ssg_state_type s, input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      SSG_ADDR_DIVIDER: v = s.divider;
      SSG_ADDR_TRIM:    v = s.trim;
      SSG_ADDR_PINCFG:  v = s.pincfg;
      SSG_ADDR_PINOUT:  v = s.pinout;
      default:          v = 16'h0000;
    endcase
    return v;
  endfunction

  // a low-to-high step between last cycle's sample and this one
  function automatic logic rise_of(input logic prev, input logic now);
    return now & ~prev;
  endfunction

  // a disabled input buffer reads low, so it can never start a sample
  function automatic logic gate_pin(input logic pin, input logic en);
    return pin & en;
  endfunction

  // shared wrap test for the tick divider and the sample period counter
  function automatic logic at_end(input logic [17:0] cnt, input logic [17:0] last);
    return cnt >= last;
  endfunction

  always_comb begin
    logic          slow_tick;
    logic          pin0_edge;
    logic          pin1_edge;
    logic [17:0]   period;
    ssg_sync_type  mode;
    slow_tick = 1'b0;
    pin0_edge = 1'b0;
    pin1_edge = 1'b0;
    period    = 18'h00000;
    mode      = sample_sync_select;
    s_d       = s_q;
    s_d.start = 1'b0;

    // register writes; reserved bits store whatever the host writes
    if (REQ.wr_en) begin
      case (REQ.addr)
        SSG_ADDR_DIVIDER: s_d.divider = REQ.wdata;
        // upper trim byte is reserved, kept as written
        SSG_ADDR_TRIM:    s_d.trim    = REQ.wdata;
        SSG_ADDR_PINCFG:  s_d.pincfg  = REQ.wdata;
        SSG_ADDR_PINOUT:  s_d.pinout  = REQ.wdata;
        default:          s_d.divider = s_q.divider;
      endcase
    end
    // a read beside a write to the same index returns the old word
    s_d.rvalid = REQ.rd_en;
    if (REQ.rd_en) begin
      s_d.rdata = read_reg(s_q, REQ.addr);
    end

    // input buffers gate the pins, so a disabled input never triggers
    s_d.pin0_prev = gate_pin(PIN0_I, pin0_input_enable);
    s_d.pin1_prev = gate_pin(PIN1_I, pin1_input_enable);
    pin0_edge     = rise_of(s_q.pin0_prev, s_d.pin0_prev);
    pin1_edge     = rise_of(s_q.pin1_prev, s_d.pin1_prev);

    // 32 kHz enable from the system clock; 10 MHz is not an exact multiple
    if (at_end(18'(s_q.slow_cnt), 18'(SLOW_CYCLES - 1))) begin
      s_d.slow_cnt = 16'h0000;
      slow_tick    = 1'b1;
    end else begin
      s_d.slow_cnt = s_q.slow_cnt + 16'h0001;
    end

    period = 18'(sample_rate_divider) * 18'(SSG_TICKS_PER_DIV);
    case (mode)
      SSG_SYNC_INTERNAL: begin
        // a divider of zero stops sampling rather than running flat out
        if (slow_tick && period != 18'h00000) begin
          if (at_end(s_q.tick_cnt, period - 18'h00001)) begin
            s_d.tick_cnt = 18'h00000;
            s_d.start    = 1'b1;
          end else begin
            s_d.tick_cnt = s_q.tick_cnt + 18'h00001;
          end
        end
      end
      SSG_SYNC_PIN0: begin
        s_d.tick_cnt = 18'h00000;
        s_d.start    = pin0_edge;
      end
      SSG_SYNC_PIN1: begin
        s_d.tick_cnt = 18'h00000;
        s_d.start    = pin1_edge;
      end
      default: begin
        // reserved code: no sample cycles
        s_d.tick_cnt = 18'h00000;
      end
    endcase

    // with the driver off the level is held low, never left stale
    s_d.pin1_oe_n = ~s_d.pincfg[SSG_BIT_PIN1_OE];
    s_d.pin1_o    = s_d.pincfg[SSG_BIT_PIN1_OE] & s_d.pinout[SSG_BIT_PIN1_LVL];
  end

  always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= SSG_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // RDATA holds the last read word until the next read strobe
  assign RDATA           = s_q.rdata;
  assign RVALID          = s_q.rvalid;
  assign PIN1_O          = s_q.pin1_o;
  assign PIN1_OE_N       = s_q.pin1_oe_n;
  assign PIN0_IN_EN      = s_q.pincfg[SSG_BIT_PIN0_IE];
  assign PIN1_IN_EN      = s_q.pincfg[SSG_BIT_PIN1_IE];
  assign FAST_CLOCK_TRIM = s_q.trim[SSG_TRIM_W-1:0];
  assign SAMPLE_START    = s_q.start;

endmodule
`default_nettype wire

// >>> logic/ssg_pkg.sv
package ssg_pkg;

  // register indices
  localparam logic [7:0] SSG_ADDR_DIVIDER = 8'h12;
  localparam logic [7:0] SSG_ADDR_TRIM    = 8'h4D;
  localparam logic [7:0] SSG_ADDR_PINCFG  = 8'h4F;
  localparam logic [7:0] SSG_ADDR_PINOUT  = 8'h50;

  // reset values
  localparam logic [15:0] SSG_RST_DIVIDER = 16'h0028;
  localparam logic [15:0] SSG_RST_TRIM    = 16'h0098;
  localparam logic [15:0] SSG_RST_PINCFG  = 16'h2090;
  localparam logic [15:0] SSG_RST_PINOUT  = 16'h0000;

  // field positions
  localparam int SSG_BIT_PIN0_IE   = 1;
  localparam int SSG_BIT_SYNC_LO   = 2;
  localparam int SSG_BIT_PIN1_IE   = 5;
  localparam int SSG_BIT_PIN1_OE   = 6;
  localparam int SSG_BIT_PIN1_LVL  = 6;
  localparam int SSG_TRIM_W        = 8;

  // timing
  localparam int SSG_CLK_HZ        = 10_000_000;
  localparam int SSG_SLOW_HZ       = 32_000;
  localparam int SSG_SLOW_CYCLES   = SSG_CLK_HZ / SSG_SLOW_HZ;
  localparam int SSG_TICKS_PER_DIV = 4;

  typedef enum logic [1:0] {
    SSG_SYNC_INTERNAL = 2'b00,
    SSG_SYNC_PIN0     = 2'b01,
    SSG_SYNC_PIN1     = 2'b10,
    SSG_SYNC_RESERVED = 2'b11
  } ssg_sync_type;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ssg_req_type;

endpackage

// >>> sim/ssg_props.sv
`timescale 1ns/1ps
`default_nettype none
module ssg_props
  import ssg_pkg::*;
(
  input wire logic                 CLK_SYS,
  input wire logic                 ARST_N,
  input wire ssg_pkg::ssg_req_type REQ,
  input wire logic                 PIN0_I,
  input wire logic                 PIN1_I,
  input wire logic                 PIN1_O,
  input wire logic                 PIN1_OE_N,
  input wire logic                 PIN0_IN_EN,
  input wire logic                 PIN1_IN_EN,
  input wire logic [7:0]           FAST_CLOCK_TRIM,
  input wire logic                 SAMPLE_START
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // mode copied from host writes: the register itself is hidden
  logic [1:0] sel_q;
  always_ff @(posedge CLK_SYS or negedge ARST_N)
    if (!ARST_N) sel_q <= 2'b00;
    else if (REQ.wr_en && REQ.addr == 8'h4F) sel_q <= REQ.wdata[3:2];
  sequence s_cfg_wr;
    REQ.wr_en && REQ.addr == 8'h4F;
  endsequence
  sequence s_trim_wr;
    REQ.wr_en && REQ.addr == 8'h4D;
  endsequence
  sequence s_edge0;
    sel_q == 2'b01 && PIN0_IN_EN && $rose(PIN0_I);
  endsequence
  sequence s_edge1;
    sel_q == 2'b10 && PIN1_IN_EN && $rose(PIN1_I);
  endsequence
  chk_trim_write: assert property (s_trim_wr |=> FAST_CLOCK_TRIM == 8'($past(REQ.wdata)))
    else $error("trim port does not follow write");
  chk_trim_hold: assert property (!(REQ.wr_en && REQ.addr == 8'h4D)
    |=> $stable(FAST_CLOCK_TRIM))
    else $error("trim port changed without write");
  chk_pin0_ie: assert property (s_cfg_wr |=> PIN0_IN_EN == $past(REQ.wdata[1]))
    else $error("pin 0 input enable wrong");
  chk_pin1_oe: assert property (s_cfg_wr |=> PIN1_OE_N == !$past(REQ.wdata[6]))
    else $error("pin 1 driver enable wrong");
  chk_pin1_ie: assert property (s_cfg_wr |=> PIN1_IN_EN == $past(REQ.wdata[5]))
    else $error("pin 1 input enable wrong");
  chk_drv_off: assert property (PIN1_OE_N |-> !PIN1_O)
    else $error("pin 1 level high while driver off");
  chk_pin0_start: assert property (s_edge0 |-> ##[1:2] SAMPLE_START)
    else $error("pin 0 edge gave no sample start");
  chk_pin1_start: assert property (s_edge1 |-> ##[1:2] SAMPLE_START)
    else $error("pin 1 edge gave no sample start");
  chk_reserved_idle: assert property (sel_q == 2'b11 |=> !SAMPLE_START)
    else $error("sample start in reserved mode");
  chk_start_pulse: assert property (SAMPLE_START |=> !SAMPLE_START)
    else $error("sample start longer than one cycle");
endmodule
`default_nettype wire

// >>> sim/ssg_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module ssg_trig_src (
  input  wire logic       clk,
  input  wire logic [1:0] fire,
  output var  logic [1:0] pin
);
  // one high cycle per request; requests are spaced, so a low cycle follows
  initial pin = 2'b00;
  always @(posedge clk) pin <= #1 fire;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssg_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  ssg_req_type req     = '0;
  logic [1:0]  fire    = 2'b00;
  logic [1:0]  pin;
  logic [15:0] rdata, v;
  logic [7:0]  trim;
  logic        rvalid, p1_o, p1_oe_n, p0_ie, p1_ie, start;
  int          error_cnt = 0, samples_checked = 0, seed = 4300, n;
  ssg_top #(.SLOW_CYCLES(4)) dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REQ(req),
    .RDATA(rdata), .RVALID(rvalid), .PIN0_I(pin[0]), .PIN1_I(pin[1]), .PIN1_O(p1_o),
    .PIN1_OE_N(p1_oe_n), .PIN0_IN_EN(p0_ie), .PIN1_IN_EN(p1_ie),
    .FAST_CLOCK_TRIM(trim), .SAMPLE_START(start));
  ssg_trig_src src (.clk(clk_sys), .fire(fire), .pin(pin));
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [15:0] cfg(int s, int e);
    return 16'h2090 | 16'(s << 2) | 16'(e * 34);
  endfunction
  task automatic check(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk_sys) #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys) #1 req = '0;
    @(posedge clk_sys) #1;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge clk_sys) #1 req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys) #1 req = '0;
    check(rvalid, 16'h0001);
    check(rdata, e);
  endtask
  task automatic pulse(int p, int cyc, output int cnt);
    cnt = 0;
    @(posedge clk_sys) #1 fire = 2'(1 << p);
    @(posedge clk_sys) #1 fire = 2'b00;
    repeat (cyc) begin
      @(posedge clk_sys) #1 cnt += start;
    end
  endtask
  task automatic rate(logic [15:0] dv);
    wr(8'h12, dv);
    wr(8'h4F, cfg(0, 0));
    for (n = 0; start !== 1'b1; n++) begin
      if (n == 400) begin
        $display("[ERR] %0t no sample pulse", $time);
        error_cnt++;
        close_out();
      end
      @(posedge clk_sys) #1;
    end
    // period is 4 ticks of 4 clocks per divider step
    pulse(2, 128 * dv - 2, n);
    check(16'(n), 16'h0008);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    check(trim, 16'h0098);
    check({p1_oe_n, p0_ie, p1_ie}, 16'h0004);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(8'h4F, 16'h2090);
    rd(8'h50, 16'h0000);
    rd(8'h12, 16'h0028);
    rd(8'h33, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h00FF : 16'($random(seed)) & 16'h00FF;
      wr(8'h4D, v);
      rd(8'h4D, v);
      check(trim, v[7:0]);
    end
    wr(8'h50, 16'h0040);
    check(p1_o, 16'h0000);
    wr(8'h4F, 16'h20D0);
    check({p1_oe_n, p1_o}, 16'h0001);
    wr(8'h50, 16'h0000);
    check({p1_oe_n, p1_o}, 16'h0000);
    wr(8'h12, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        wr(8'h4F, cfg(s, e));
        rd(8'h4F, cfg(s, e));
        for (int p = 0; p < 2; p++) begin
          pulse(p, 8, n);
          check(16'(n), 16'(e == 1 && s == p + 1));
        end
      end
    end
    rate(16'h0001);
    rate(16'h0003);
    arst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check(trim, 16'h0098);
    check({p1_oe_n, p1_o, start}, 16'h0004);
    arst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(8'h4D, 16'h0098);
    rd(8'h12, 16'h0028);
    close_out();
  end
endmodule
bind ssg_top ssg_props chk (.CLK_SYS, .ARST_N, .REQ, .PIN0_I, .PIN1_I, .PIN1_O,
  .PIN1_OE_N, .PIN0_IN_EN, .PIN1_IN_EN, .FAST_CLOCK_TRIM, .SAMPLE_START);
`default_nettype wire
